// file: hdl/dicmd_pkg.sv
/*
 Shared constants and types of the digital input command decoder.
 Assumes a 10 MHz control clock and a plain register port.
*/
package dicmd_pkg;
	// Clock and time base
	localparam int CLK_PERIOD_NS = 100;
	localparam int TIME_UNIT_MS = 10;
	localparam int UNIT_CYCLES = TIME_UNIT_MS * 1000000 / CLK_PERIOD_NS;
	localparam int GATE_MS = 10;
	localparam int GATE_CYCLES = GATE_MS * 1000000 / CLK_PERIOD_NS;

	// Terminal function codes
	localparam logic [7:0] FN_CANCEL_LOOP = 8'h14;
	localparam logic [7:0] FN_INVERT = 8'h15;
	localparam logic [7:0] FN_INTERLOCK = 8'h16;
	localparam logic [7:0] FN_CANCEL_TORQUE = 8'h17;
	localparam logic [7:0] FN_LINK = 8'h18;
	localparam logic [7:0] FN_MONITOR = 8'h19;
	localparam logic [7:0] FN_SEARCH = 8'h1a;
	localparam logic [7:0] FN_FORCED_STOP = 8'h1e;
	localparam logic [7:0] FN_PREEXCITE = 8'h20;
	localparam logic [7:0] FN_ACC_CLEAR = 8'h21;
	localparam logic [7:0] FN_INT_FREEZE = 8'h22;
	localparam logic [7:0] FN_KEYPAD = 8'h23;
	localparam logic [7:0] FN_OVERLOAD = 8'h2e;
	localparam logic [7:0] FN_SERVO = 8'h2f;
	localparam logic [7:0] FN_PULSE = 8'h30;
	localparam logic [7:0] FN_SIGN = 8'h31;
	localparam logic [7:0] FN_NONE = 8'h00;
	localparam int FIFTH_INDEX = 4;

	// Configuration encodings
	localparam logic [1:0] LOOP_OFF = 2'h0;
	localparam logic [1:0] LOOP_NORMAL = 2'h1;
	localparam logic [1:0] LOOP_INVERSE = 2'h2;
	localparam logic [1:0] TORQUE_A = 2'h2;
	localparam logic [1:0] TORQUE_B = 2'h3;
	localparam logic [7:0] ALARM_NONE = 8'h00;
	localparam logic [7:0] ALARM_FORCED_STOP = 8'h06;

	// Register byte addresses
	localparam logic [7:0] ADDR_CONFIG = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_DECEL = 8'h08;
	localparam logic [7:0] ADDR_PREEXCITE = 8'h0c;
	localparam logic [7:0] ADDR_MONITOR = 8'h10;
	localparam logic [7:0] ADDR_PULSE = 8'h14;
	localparam logic [7:0] ADDR_ASSIGN0 = 8'h20;

	// Configuration register fields
	localparam int CFG_DIR_BIT = 0;
	localparam int CFG_LOOP_LSB = 1;
	localparam int CFG_TORQUE_LSB = 3;
	localparam int CFG_SENSOR_BIT = 5;
	localparam int CFG_ALARM_CLR_BIT = 7;

	// Reset values
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [15:0] DECEL_RESET = 16'h0064;
	localparam logic [15:0] PREEXCITE_RESET = 16'h0000;

	typedef enum {ST_IDLE, ST_PREEXCITE, ST_RUN, ST_DECEL, ST_ALARM} drive_state_t;

	typedef struct packed {
		logic loopEnable;
		logic manualReference;
		logic analogInverse;
		logic loopInverse;
		logic manualInverse;
		logic powerFailDetected;
		logic speedControl;
		logic linkPriority;
		logic speedSearch;
		logic preexcite;
		logic accumulatorClear;
		logic integralFreeze;
		logic keypadSource;
		logic overloadStopEnable;
		logic servoLock;
		logic pulseFreqSelect;
		logic pulseNegative;
	} drive_cmd_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
endpackage

// file: hdl/drive_input_command_decoder.sv
/*
 Decoder for the functions assigned to the drive's digital input terminals.
 Terminals are asynchronous pins; runRequest comes from the control core on sys_clk.
 Registers are reached over a plain address/strobe port, read data one cycle late.
*/
// Local design decisions: the register addresses and the plain strobed port.
// Operation
// [RULE1] Cancel-loop input disables loop, uses manual reference
// [RULE2] Invert affects only setting one analog sources
// [RULE3] Analog direction is config XOR invert input
// [RULE4] Loop direction from mode, swapped by invert
// [RULE5] Cancelled loop: manual direction follows config only
// [RULE6] Interlock input marks momentary power failure detected
// [RULE7] Under torque config, cancel input selects speed
// [RULE8] Link-select gives link priority; unassigned means active
// [RULE9] Monitor inputs only reported, never act
// [RULE10] Speed-search input sampled at start of run
// [RULE11] Forced stop off: decelerate, then forced-stop alarm
// [RULE12] Pre-excite by input, or automatically with sensor
// [RULE13] Loop-reset input clears integral and differential
// [RULE14] Loop-hold input freezes integral accumulator
// [RULE15] Local input selects keypad run and frequency
// [RULE16] Overload-stop input enables; unassigned means enabled
// [RULE17] Servo-lock input enables position holding
// [RULE18] Only fifth input carries pulse-train frequency
// [RULE19] Pulse sign on any other input
// [RULE20] Each terminal holds a function assignment code
`timescale 1ns/1ps
module drive_input_command_decoder #(
	parameter int NUM_INPUTS = 8,
	parameter int UNIT_CYCLES = dicmd_pkg::UNIT_CYCLES,
	parameter int GATE_CYCLES = dicmd_pkg::GATE_CYCLES
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [NUM_INPUTS-1:0] terminalIn,
	input wire logic runRequest,
	input wire dicmd_pkg::reg_req_t regReq,
	output logic [31:0] regRdata,
	output dicmd_pkg::drive_cmd_t driveCmd,
	output logic decelerating,
	output logic running,
	output logic alarmActive,
	output logic [7:0] alarmCode,
	output logic [15:0] pulseFreq
);

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisers

	logic [NUM_INPUTS-1:0] syncMeta;
	logic [NUM_INPUTS-1:0] level;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			syncMeta <= '0;
			level <= '0;
		end else begin
			syncMeta <= terminalIn;
			level <= syncMeta;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	logic [7:0] config_;
	logic [15:0] decelTime;
	logic [15:0] preexciteTime;
	logic [7:0] assignCode [NUM_INPUTS];
	logic [31:0] rdata;
	logic alarmClear;
	logic [7:0] next_config;
	logic [15:0] next_decelTime;
	logic [15:0] next_preexciteTime;
	logic [7:0] next_assignCode [NUM_INPUTS];
	logic [31:0] next_rdata;
	logic [NUM_INPUTS-1:0] monitorBits;
	typedef enum {ST_IDLE, ST_PREEXCITE, ST_RUN, ST_DECEL, ST_ALARM} drive_state_t;
	drive_state_t state;

	function automatic logic isAssignAddr(input logic [7:0] addr, input int idx);
		isAssignAddr = addr == 8'(dicmd_pkg::ADDR_ASSIGN0 + 8'(idx * 4));
	endfunction

	always_comb begin
		next_config = config_;
		next_decelTime = decelTime;
		next_preexciteTime = preexciteTime;
		next_assignCode = assignCode;
		next_rdata = 32'h0000_0000;
		alarmClear = 1'b0;
		if (regReq.wr) begin
			case (regReq.addr)
				dicmd_pkg::ADDR_CONFIG: begin
					next_config = regReq.wdata[7:0];
					next_config[dicmd_pkg::CFG_ALARM_CLR_BIT] = 1'b0;
					alarmClear = regReq.wdata[dicmd_pkg::CFG_ALARM_CLR_BIT];
				end
				dicmd_pkg::ADDR_DECEL: next_decelTime = regReq.wdata[15:0];
				dicmd_pkg::ADDR_PREEXCITE: next_preexciteTime = regReq.wdata[15:0];
				default: begin
					for (int i = 0; i < NUM_INPUTS; i++) begin
						if (isAssignAddr(regReq.addr, i)) begin
							next_assignCode[i] = regReq.wdata[7:0]; // RULE20
						end
					end
				end
			endcase
		end
		if (regReq.rd) begin
			case (regReq.addr)
				dicmd_pkg::ADDR_CONFIG: next_rdata = {24'h00_0000, config_};
				dicmd_pkg::ADDR_STATUS: next_rdata = {alarmCode, 3'h0, decelerating, running,
					alarmActive, 1'b0, driveCmd};
				dicmd_pkg::ADDR_DECEL: next_rdata = {16'h0000, decelTime};
				dicmd_pkg::ADDR_PREEXCITE: next_rdata = {16'h0000, preexciteTime};
				dicmd_pkg::ADDR_MONITOR: next_rdata = 32'(monitorBits); // RULE9
				dicmd_pkg::ADDR_PULSE: next_rdata = {16'h0000, pulseFreq};
				default: begin
					for (int i = 0; i < NUM_INPUTS; i++) begin
						if (isAssignAddr(regReq.addr, i)) begin
							next_rdata = {24'h00_0000, assignCode[i]};
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			config_ <= dicmd_pkg::CONFIG_RESET;
			decelTime <= dicmd_pkg::DECEL_RESET;
			preexciteTime <= dicmd_pkg::PREEXCITE_RESET;
			for (int i = 0; i < NUM_INPUTS; i++) begin
				assignCode[i] <= dicmd_pkg::FN_NONE;
			end
			rdata <= 32'h0000_0000;
		end else begin
			config_ <= next_config;
			decelTime <= next_decelTime;
			preexciteTime <= next_preexciteTime;
			assignCode <= next_assignCode;
			rdata <= next_rdata;
		end
	end

	assign regRdata = rdata;

	////////////////////////////////////////////////////////////////////////////////
	// Function decode

	logic [63:0] fnLevel;
	logic [63:0] fnAssigned;

	always_comb begin
		fnLevel = 64'h0000_0000_0000_0000;
		fnAssigned = 64'h0000_0000_0000_0000;
		monitorBits = '0;
		for (int i = 0; i < NUM_INPUTS; i++) begin
			if (assignCode[i][7:6] == 2'h0
				&& !(assignCode[i] == dicmd_pkg::FN_PULSE && i != dicmd_pkg::FIFTH_INDEX) // RULE18
				&& !(assignCode[i] == dicmd_pkg::FN_SIGN && i == dicmd_pkg::FIFTH_INDEX)) begin // RULE19
				fnAssigned[assignCode[i][5:0]] = 1'b1; // RULE20
				fnLevel[assignCode[i][5:0]] = fnLevel[assignCode[i][5:0]] | level[i];
			end
			monitorBits[i] = assignCode[i] == dicmd_pkg::FN_MONITOR && level[i]; // RULE9
		end
	end

	function automatic logic fnOn(input logic [63:0] lv, input logic [7:0] code);
		fnOn = lv[code[5:0]];
	endfunction

	logic cfgDir;
	logic [1:0] loopMode;
	logic [1:0] torqueCfg;
	logic sensorVector;
	logic invertIn;
	logic loopCancelled;

	always_comb begin
		cfgDir = config_[dicmd_pkg::CFG_DIR_BIT];
		loopMode = config_[dicmd_pkg::CFG_LOOP_LSB +: 2];
		torqueCfg = config_[dicmd_pkg::CFG_TORQUE_LSB +: 2];
		sensorVector = config_[dicmd_pkg::CFG_SENSOR_BIT];
		invertIn = fnOn(fnLevel, dicmd_pkg::FN_INVERT);
		loopCancelled = fnOn(fnLevel, dicmd_pkg::FN_CANCEL_LOOP);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Run sequence

	logic [$clog2(UNIT_CYCLES)-1:0] unitCount;
	logic [15:0] phaseCount;
	logic searchLatch;
	logic stopPrev;
	logic [7:0] alarmReg;
	logic [$clog2(UNIT_CYCLES)-1:0] next_unitCount;
	logic [15:0] next_phaseCount;
	logic next_searchLatch;
	logic next_stopPrev;
	logic [7:0] next_alarmReg;
	drive_state_t next_state;
	logic stopLevel;
	logic unitTick;
	logic autoPreexcite;

	always_comb begin
		stopLevel = fnOn(fnLevel, dicmd_pkg::FN_FORCED_STOP)
			| !fnOn(fnAssigned, dicmd_pkg::FN_FORCED_STOP);
		unitTick = unitCount == ($clog2(UNIT_CYCLES))'(UNIT_CYCLES - 1);
		autoPreexcite = sensorVector && preexciteTime != 16'h0000; // RULE12
		next_state = state;
		next_unitCount = unitTick ? '0 : unitCount + 1'b1;
		next_phaseCount = phaseCount;
		next_searchLatch = searchLatch;
		next_stopPrev = stopLevel;
		next_alarmReg = alarmReg;
		case (state)
			ST_IDLE: begin
				next_phaseCount = 16'h0000;
				if (runRequest) begin
					next_searchLatch = fnOn(fnLevel, dicmd_pkg::FN_SEARCH); // RULE10
					next_unitCount = '0;
					next_state = autoPreexcite ? ST_PREEXCITE : ST_RUN; // RULE12
				end
			end
			ST_PREEXCITE: begin
				if (!runRequest) begin
					next_state = ST_IDLE;
				end else if (unitTick) begin
					next_phaseCount = phaseCount + 16'h0001;
					if (phaseCount + 16'h0001 >= preexciteTime) begin
						next_state = ST_RUN;
					end
				end
			end
			ST_RUN: begin
				if (stopPrev && !stopLevel) begin
					next_unitCount = '0; // RULE11
					next_phaseCount = 16'h0000;
					next_state = ST_DECEL;
				end else if (!runRequest) begin
					next_state = ST_IDLE;
				end
			end
			ST_DECEL: begin
				if (unitTick) begin
					next_phaseCount = phaseCount + 16'h0001;
				end
				if (phaseCount >= decelTime) begin
					next_alarmReg = dicmd_pkg::ALARM_FORCED_STOP; // RULE11
					next_state = ST_ALARM;
				end
			end
			ST_ALARM: begin
				if (alarmClear) begin
					next_alarmReg = dicmd_pkg::ALARM_NONE;
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= ST_IDLE;
			unitCount <= '0;
			phaseCount <= 16'h0000;
			searchLatch <= 1'b0;
			stopPrev <= 1'b1;
			alarmReg <= dicmd_pkg::ALARM_NONE;
		end else begin
			state <= next_state;
			unitCount <= next_unitCount;
			phaseCount <= next_phaseCount;
			searchLatch <= next_searchLatch;
			stopPrev <= next_stopPrev;
			alarmReg <= next_alarmReg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pulse train measurement on the fifth terminal

	logic [$clog2(GATE_CYCLES)-1:0] gateCount;
	logic [15:0] edgeCount;
	logic [15:0] freqReg;
	logic pulsePrev;
	logic [$clog2(GATE_CYCLES)-1:0] next_gateCount;
	logic [15:0] next_edgeCount;
	logic [15:0] next_freqReg;
	logic pulseSel;

	always_comb begin
		pulseSel = assignCode[dicmd_pkg::FIFTH_INDEX] == dicmd_pkg::FN_PULSE; // RULE18
		next_gateCount = gateCount + 1'b1;
		next_edgeCount = edgeCount;
		next_freqReg = freqReg;
		if (pulseSel && level[dicmd_pkg::FIFTH_INDEX] && !pulsePrev && edgeCount != 16'hffff) begin
			next_edgeCount = edgeCount + 16'h0001;
		end
		if (gateCount == ($clog2(GATE_CYCLES))'(GATE_CYCLES - 1)) begin
			next_gateCount = '0;
			next_freqReg = pulseSel ? next_edgeCount : 16'h0000; // RULE18
			next_edgeCount = 16'h0000;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			gateCount <= '0;
			edgeCount <= 16'h0000;
			freqReg <= 16'h0000;
			pulsePrev <= 1'b0;
		end else begin
			gateCount <= next_gateCount;
			edgeCount <= next_edgeCount;
			freqReg <= next_freqReg;
			pulsePrev <= level[dicmd_pkg::FIFTH_INDEX];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Command word to the control core

	dicmd_pkg::drive_cmd_t next_cmd;
	dicmd_pkg::drive_cmd_t cmdReg;

	always_comb begin
		next_cmd = '0;
		next_cmd.loopEnable = loopMode != dicmd_pkg::LOOP_OFF && !loopCancelled; // RULE1
		next_cmd.manualReference = loopMode == dicmd_pkg::LOOP_OFF || loopCancelled; // RULE1
		next_cmd.analogInverse = cfgDir ^ invertIn; // RULE2 RULE3
		next_cmd.loopInverse = (loopMode == dicmd_pkg::LOOP_INVERSE) ^ invertIn; // RULE4
		next_cmd.manualInverse = (loopMode == dicmd_pkg::LOOP_OFF)
			? (cfgDir ^ invertIn) : cfgDir; // RULE5
		next_cmd.powerFailDetected = fnOn(fnLevel, dicmd_pkg::FN_INTERLOCK); // RULE6
		next_cmd.speedControl = !(torqueCfg == dicmd_pkg::TORQUE_A || torqueCfg == dicmd_pkg::TORQUE_B)
			|| fnOn(fnLevel, dicmd_pkg::FN_CANCEL_TORQUE); // RULE7
		next_cmd.linkPriority = fnOn(fnLevel, dicmd_pkg::FN_LINK)
			|| !fnOn(fnAssigned, dicmd_pkg::FN_LINK); // RULE8
		next_cmd.speedSearch = searchLatch; // RULE10
		next_cmd.preexcite = fnOn(fnLevel, dicmd_pkg::FN_PREEXCITE)
			|| state == ST_PREEXCITE; // RULE12
		next_cmd.accumulatorClear = fnOn(fnLevel, dicmd_pkg::FN_ACC_CLEAR); // RULE13
		next_cmd.integralFreeze = fnOn(fnLevel, dicmd_pkg::FN_INT_FREEZE); // RULE14
		next_cmd.keypadSource = fnOn(fnLevel, dicmd_pkg::FN_KEYPAD); // RULE15
		next_cmd.overloadStopEnable = fnOn(fnLevel, dicmd_pkg::FN_OVERLOAD)
			|| !fnOn(fnAssigned, dicmd_pkg::FN_OVERLOAD); // RULE16
		next_cmd.servoLock = fnOn(fnLevel, dicmd_pkg::FN_SERVO); // RULE17
		next_cmd.pulseFreqSelect = pulseSel; // RULE18
		next_cmd.pulseNegative = pulseSel && fnOn(fnLevel, dicmd_pkg::FN_SIGN); // RULE19
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cmdReg <= '0;
		end else begin
			cmdReg <= next_cmd;
		end
	end

	assign driveCmd = cmdReg;
	assign decelerating = state == ST_DECEL;
	assign running = state == ST_RUN || state == ST_DECEL;
	assign alarmActive = state == ST_ALARM;
	assign alarmCode = alarmReg;
	assign pulseFreq = freqReg;

endmodule

// file: tb/terminal_sequencer.sv
/*
 Model of the sequence controller that drives the terminal pins.
 Assumes the bench calls its tasks; levels change just after a sys_clk edge.
*/
`timescale 1ns/1ps
module terminal_sequencer (
	input wire logic sys_clk,
	output logic [7:0] pins
);
	initial pins = 8'h00;
	////////////////////////////////////////
	// Sets all pins just after a sys_clk edge; levels hold between calls
	task automatic put(input logic [7:0] v);
		@(posedge sys_clk);
		pins <= v;
	endtask
	// Toggles one pin every cycle: a rising edge each second cycle
	task automatic toggle(input int idx, input int n);
		repeat (n) begin
			// Read after the edge so a level put just before is kept
			@(posedge sys_clk);
			pins <= pins ^ (8'h01 << idx);
		end
	endtask
endmodule

// file: tb/drive_input_command_decoder_assertions.sv
/*
 Port checks of the terminal command decoder.
 Assumes binding to the decoder, one clock, reset active high.
*/
`timescale 1ns/1ps
module drive_input_command_decoder_assertions (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire dicmd_pkg::reg_req_t regReq,
	input wire logic [31:0] regRdata,
	input wire dicmd_pkg::drive_cmd_t driveCmd,
	input wire logic decelerating,
	input wire logic running,
	input wire logic alarmActive,
	input wire logic [7:0] alarmCode
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////
	property p_read_idle;
		!$past(regReq.rd) |-> regRdata == 32'h0000_0000;
	endproperty
	a_read_idle: assert property (p_read_idle) else $error("read data outside read");
	property p_status;
		$past(regReq.rd) && $past(regReq.addr) == dicmd_pkg::ADDR_STATUS
			|-> regRdata[16:0] == $past(driveCmd) && regRdata[19] == $past(running);
	endproperty
	a_status: assert property (p_status) else $error("status word mismatch");
	property p_alarm_code;
		alarmActive |-> alarmCode == dicmd_pkg::ALARM_FORCED_STOP && !running;
	endproperty
	a_alarm_code: assert property (p_alarm_code) else $error("alarm code wrong");
	property p_decel_end;
		$fell(decelerating) |-> alarmActive;
	endproperty
	a_decel_end: assert property (p_decel_end) else $error("no alarm after stop");
	property p_decel_len;
		$rose(decelerating) |-> decelerating[*8];
	endproperty
	a_decel_len: assert property (p_decel_len) else $error("deceleration too short");
	property p_alarm_hold;
		alarmActive && !(regReq.wr && regReq.addr == dicmd_pkg::ADDR_CONFIG && regReq.wdata[7])
			|=> alarmActive;
	endproperty
	a_alarm_hold: assert property (p_alarm_hold) else $error("alarm lost");
	property p_sign;
		driveCmd.pulseNegative |-> driveCmd.pulseFreqSelect;
	endproperty
	a_sign: assert property (p_sign) else $error("sign without pulse input");
	property p_loop;
		driveCmd.loopEnable |-> !driveCmd.manualReference;
	endproperty
	a_loop: assert property (p_loop) else $error("loop and manual together");
endmodule

// file: tb/drive_input_command_decoder_test.sv
/*
 Self-checking bench of the terminal command decoder.
 Assumes the package, the decoder, the sequencer model and the checker are compiled.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
	checksDone++; \
	if ((g) !== (e)) begin \
		errors++; \
		$display("Error %s expected %h seen %h", nm, (e), (g)); \
	end \
end
module drive_input_command_decoder_test;
	localparam int U = 10;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic runRequest = 1'b0;
	dicmd_pkg::reg_req_t regReq = '0;
	logic [7:0] pins;
	logic [31:0] regRdata;
	dicmd_pkg::drive_cmd_t driveCmd;
	logic decelerating, running, alarmActive, rdLate = 1'b0, dir = 1'b0;
	logic [7:0] alarmCode;
	logic [15:0] pulseFreq;
	logic [31:0] expQ[$], mskQ[$];
	logic [7:0] asg[8];
	logic [1:0] loopMode = 2'h0, torq = 2'h0;
	logic [7:0] codes[17] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1e, 8'h20,
		8'h21, 8'h22, 8'h23, 8'h2e, 8'h2f, 8'h30, 8'h31, 8'h00};
	int errors = 0, checksDone = 0, n;
	drive_input_command_decoder #(.NUM_INPUTS(8), .UNIT_CYCLES(U), .GATE_CYCLES(U))
		drive_input_command_decoder_inst (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.terminalIn(pins), .runRequest(runRequest), .regReq(regReq), .regRdata(regRdata),
		.driveCmd(driveCmd), .decelerating(decelerating), .running(running),
		.alarmActive(alarmActive), .alarmCode(alarmCode), .pulseFreq(pulseFreq));
	terminal_sequencer terminal_sequencer_inst (.sys_clk(sys_clk), .pins(pins));
	always #50 sys_clk = ~sys_clk;
	////////////////////////////////////////
	// Results checker: a read's note is taken off when its data stand
	always @(posedge sys_clk) rdLate <= regReq.rd;
	always @(negedge sys_clk) if (rdLate) begin
		`CHK("read data", expQ[0], regRdata & mskQ[0])
		void'(expQ.pop_front());
		void'(mskQ.pop_front());
	end
	////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		regReq.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
		expQ.push_back(e & m);
		mskQ.push_back(m);
		@(posedge sys_clk);
		regReq <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		regReq.rd <= 1'b0;
	endtask
	task automatic assign_all();
		for (int i = 0; i < 8; i++) begin
			wr(dicmd_pkg::ADDR_ASSIGN0 + 8'(4 * i), {24'h0, asg[i]});
		end
	endtask
	task automatic wait_run(output int c);
		c = 0;
		while (running !== 1'b1 && c < 300) begin
			@(posedge sys_clk);
			#1;
			c++;
		end
	endtask
	function automatic logic act(input logic [7:0] c);
		act = 1'b0;
		for (int i = 0; i < 8; i++) begin
			act |= asg[i] == c && pins[i] && !(i == 4 && c == dicmd_pkg::FN_SIGN);
		end
	endfunction
	function automatic logic has(input logic [7:0] c);
		has = 1'b0;
		for (int i = 0; i < 8; i++) begin
			has |= asg[i] == c;
		end
	endfunction
	function automatic logic [31:0] monBits();
		monBits = '0;
		for (int i = 0; i < 8; i++) begin
			monBits[i] = asg[i] == dicmd_pkg::FN_MONITOR && pins[i];
		end
	endfunction
	task automatic rd_status();
		dicmd_pkg::drive_cmd_t e;
		e = '0;
		e.loopEnable = loopMode != 2'h0 && !act(dicmd_pkg::FN_CANCEL_LOOP);
		e.manualReference = !e.loopEnable;
		e.analogInverse = dir ^ act(dicmd_pkg::FN_INVERT);
		e.loopInverse = (loopMode == 2'h2) ^ act(dicmd_pkg::FN_INVERT);
		e.manualInverse = loopMode != 2'h0 ? dir : dir ^ act(dicmd_pkg::FN_INVERT);
		e.powerFailDetected = act(dicmd_pkg::FN_INTERLOCK);
		e.speedControl = torq[1] ? act(dicmd_pkg::FN_CANCEL_TORQUE) : 1'b1;
		e.linkPriority = has(dicmd_pkg::FN_LINK) ? act(dicmd_pkg::FN_LINK) : 1'b1;
		e.preexcite = act(dicmd_pkg::FN_PREEXCITE);
		e.accumulatorClear = act(dicmd_pkg::FN_ACC_CLEAR);
		e.integralFreeze = act(dicmd_pkg::FN_INT_FREEZE);
		e.keypadSource = act(dicmd_pkg::FN_KEYPAD);
		e.overloadStopEnable = !has(dicmd_pkg::FN_OVERLOAD) || act(dicmd_pkg::FN_OVERLOAD);
		e.servoLock = act(dicmd_pkg::FN_SERVO);
		e.pulseFreqSelect = asg[4] == dicmd_pkg::FN_PULSE;
		e.pulseNegative = e.pulseFreqSelect && act(dicmd_pkg::FN_SIGN);
		rd(dicmd_pkg::ADDR_STATUS, {15'h0, e}, e.loopEnable ? 32'hFFFF_EEFF : 32'hFFFF_DEFF);
	endtask
	task automatic print_verdict();
		$display("Counts: %0d checks, %0d errors", checksDone, errors);
		if (errors == 0 && checksDone > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk);
		errors++;
		$display("Error watchdog expected 0 seen 1");
		print_verdict();
	end
	////////////////////////////////////////
	initial begin
		void'($urandom(20));
		asg = '{default: 8'h00};
		repeat (6) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rd(dicmd_pkg::ADDR_CONFIG, 32'(dicmd_pkg::CONFIG_RESET), 32'hFFFF_FFFF);
		rd(dicmd_pkg::ADDR_DECEL, 32'(dicmd_pkg::DECEL_RESET), 32'hFFFF_FFFF);
		rd(dicmd_pkg::ADDR_PREEXCITE, 32'(dicmd_pkg::PREEXCITE_RESET), 32'hFFFF_FFFF);
		wr(8'h40, 32'hFFFF_FFFF);
		wr(dicmd_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
		rd(8'h40, 32'h0000_0000, 32'hFFFF_FFFF);
		rd_status();
		$display("Test reset values done");
		for (n = 0; n < 17; n++) begin
			dir = 1'($urandom);
			loopMode = 2'($urandom % 3);
			torq = 2'($urandom);
			wr(dicmd_pkg::ADDR_CONFIG, {27'h0, torq, loopMode, dir});
			for (int i = 0; i < 8; i++) asg[i] = codes[(3 * n + i) % 17];
			assign_all();
			terminal_sequencer_inst.put(8'($urandom));
			repeat (4) @(posedge sys_clk);
			rd_status();
			rd(dicmd_pkg::ADDR_MONITOR, monBits(), 32'hFFFF_FFFF);
			rd(dicmd_pkg::ADDR_ASSIGN0 + 8'(4 * (n % 8)), {24'h0, asg[n % 8]}, 32'hFF);
		end
		$display("Test decode table done");
		asg = '{0: dicmd_pkg::FN_FORCED_STOP, 1: dicmd_pkg::FN_SEARCH, default: 8'h00};
		assign_all();
		wr(dicmd_pkg::ADDR_CONFIG, 32'h0000_0000);
		wr(dicmd_pkg::ADDR_DECEL, 32'h0000_0002);
		terminal_sequencer_inst.put(8'h03);
		repeat (4) @(posedge sys_clk);
		runRequest <= 1'b1;
		wait_run(n);
		terminal_sequencer_inst.put(8'h01);
		repeat (4) @(posedge sys_clk);
		rd(dicmd_pkg::ADDR_STATUS, 32'h0008_0100, 32'h0008_0100);
		terminal_sequencer_inst.put(8'h00);
		n = 0;
		for (int k = 0; k < 300 && alarmActive !== 1'b1; k++) begin
			@(posedge sys_clk);
			#1;
			n += int'(decelerating);
		end
		`CHK("decel cycles", 1'b1, n >= 2 * U && n <= 3 * U + 2)
		rd(dicmd_pkg::ADDR_STATUS, 32'h0604_0000, 32'hFF1C_0000);
		runRequest <= 1'b0;
		wr(dicmd_pkg::ADDR_CONFIG, 32'h0000_0080);
		rd(dicmd_pkg::ADDR_STATUS, 32'h0000_0000, 32'hFF1C_0000);
		$display("Test forced stop done");
		sys_rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		wr(dicmd_pkg::ADDR_CONFIG, 32'h0000_0020);
		wr(dicmd_pkg::ADDR_PREEXCITE, 32'h0000_0002);
		runRequest <= 1'b1;
		wait_run(n);
		`CHK("preexcite delay", 1'b1, n >= 2 * U && n <= 3 * U + 4)
		@(posedge sys_clk);
		sys_rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		wait_run(n);
		`CHK("plain start delay", 1'b1, n <= 4)
		$display("Test preexcite done");
		asg = '{2: dicmd_pkg::FN_SIGN, 4: dicmd_pkg::FN_PULSE, default: 8'h00};
		assign_all();
		terminal_sequencer_inst.put(8'h04);
		fork
			terminal_sequencer_inst.toggle(4, 60);
		join_none
		repeat (30) @(posedge sys_clk);
		rd(dicmd_pkg::ADDR_PULSE, 32'h0000_0005, 32'hFFFF_FFFF);
		#1;
		`CHK("pulse rate", 16'h0005, pulseFreq)
		rd(dicmd_pkg::ADDR_STATUS, 32'h0000_0003, 32'h0000_0003);
		repeat (2) @(posedge sys_clk);
		$display("Test pulse train done");
		print_verdict();
	end
endmodule
bind drive_input_command_decoder drive_input_command_decoder_assertions chk_inst (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .regReq(regReq), .regRdata(regRdata),
	.driveCmd(driveCmd), .decelerating(decelerating), .running(running),
	.alarmActive(alarmActive), .alarmCode(alarmCode));
